// file: inc/tcop_cfg.svh
// register offsets, field positions and reset values of the pulse block
`ifndef TCOP_CFG_SVH
`define TCOP_CFG_SVH
`define TCOP_OFS_CTRL      8'h00
`define TCOP_OFS_PSC       8'h04
`define TCOP_OFS_RATIO     8'h08
`define TCOP_OFS_LOAD      8'h0C
`define TCOP_OFS_CAPT      8'h10
`define TCOP_OFS_RLDC      8'h14
`define TCOP_OFS_ERLD      8'h18
`define TCOP_OFS_CEVT      8'h1C
`define TCOP_OFS_MEDG      8'h20
`define TCOP_OFS_CCLK      8'h24
`define TCOP_OFS_LIMIT     8'h28
`define TCOP_OFS_MCNT      8'h2C
`define TCOP_OFS_MCMP      8'h30
`define TCOP_OFS_STATUS    8'h34
`define TCOP_OFS_CLEAR     8'h38
`define TCOP_OFS_PT_START  8'h40
`define TCOP_OFS_PT_CLKSEL 8'h44
`define TCOP_OFS_OFS_CNT   8'h48
`define TCOP_OFS_ITV_CNT   8'h4C
`define TCOP_OFS_OFS_CMP0  8'h50
`define TCOP_OFS_ITV_CMP   8'h60
`define TCOP_OFS_CMPB_EN   8'h64
`define TCOP_OFS_DCNT_CTRL 8'h68
`define TCOP_OFS_DCNT0     8'h6C
`define TCOP_OFS_IRQ_SEL   8'h7C
`define TCOP_OFS_PULSES    8'h80
// control register fields
`define TCOP_CTRL_GEN_EN   0
`define TCOP_CTRL_LDSEL    1
`define TCOP_CTRL_B4_STOP  2
`define TCOP_CTRL_EVT_OUT  3
`define TCOP_CTRL_EDGE_LO  4
`define TCOP_CTRL_CB5_LO   6
// status fields
`define TCOP_ST_CAPT       0
`define TCOP_ST_MULT       1
`define TCOP_ST_CMPA_LO    8
`define TCOP_ST_CMPB       12
// reset values
`define TCOP_RST_CTRL      8'h00
`define TCOP_RST_PSC       8'h01
`define TCOP_RST_RATIO     32'h0000_0004
`define TCOP_RST_LIMIT     32'hFFFF_FFFF
`endif

// file: inc/tcop_pkg.sv
// types shared by the pulse block modules
package tcop_pkg;
  typedef enum logic [1:0] {TCOP_EDGE_NONE, TCOP_EDGE_RISE,
                            TCOP_EDGE_FALL, TCOP_EDGE_BOTH} tcop_edge_t;
  typedef enum logic [1:0] {TCOP_CB5_LS, TCOP_CB5_CORR,
                            TCOP_CB5_MULT, TCOP_CB5_EVT} tcop_cb5_t;
  typedef enum logic [1:0] {TCOP_START_OFF, TCOP_START_CMPA,
                            TCOP_START_CMPB, TCOP_START_ANY} tcop_start_t;
  typedef enum logic [1:0] {TCOP_STOP_UFLOW, TCOP_STOP_CMPB,
                            TCOP_STOP_CMPA, TCOP_STOP_ANY} tcop_stop_t;
endpackage

// file: inc/tcop_ch_if.sv
// one pulse channel: controls toward a down-counter and its state back
`timescale 1ns/100ps
interface tcop_ch_if #(parameter int CW = 32);
  logic          tick;
  logic          start;
  logic          stop;
  logic [CW-1:0] width;
  logic [CW-1:0] cnt;
  logic          pulse;
  modport ctl (output tick, output start, output stop, output width,
               input cnt, input pulse);
  modport ch (input tick, input start, input stop, input width,
              output cnt, output pulse);
endinterface

// file: core/tcop_edge.sv
// programmable edge detector on the tooth input
`timescale 1ns/100ps
module tcop_edge
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic       tooth_input,
  input  wire logic [1:0] edge_sel,
  output logic            edge_evt
);
  logic prev_q;
  logic rise;
  logic fall;

  // previous level of the tooth input
  always_ff @(posedge clk or posedge rst)
    if (rst)
      prev_q <= 1'b0;
    else if (ce)
      prev_q <= tooth_input;

  // edge selection
  assign rise = tooth_input & ~prev_q;
  assign fall = ~tooth_input & prev_q;
  always_comb
  begin
    case (tcop_pkg::tcop_edge_t'(edge_sel))
      tcop_pkg::TCOP_EDGE_RISE: edge_evt = ce & rise;
      tcop_pkg::TCOP_EDGE_FALL: edge_evt = ce & fall;
      tcop_pkg::TCOP_EDGE_BOTH: edge_evt = ce & (rise | fall);
      default:                  edge_evt = 1'b0;
    endcase
  end
endmodule

// file: core/tcop_dcnt.sv
// one-shot down-counter channel
`timescale 1ns/100ps
module tcop_dcnt #(parameter int CW = 32)
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  tcop_ch_if.ch     ch
);
  logic [CW-1:0] cnt_q;
  logic          act_q;

  // load, decrement and underflow of the counter
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      cnt_q <= '0;
      act_q <= 1'b0;
    end
    else if (ce)
    begin
      if (ch.start)
      begin
        cnt_q <= ch.width;
        act_q <= 1'b1;
      end
      else if (act_q && ch.stop)
        act_q <= 1'b0;
      else if (act_q && ch.tick)
      begin
        if (cnt_q == '0)
          act_q <= 1'b0;
        else
          cnt_q <= cnt_q - 1'b1;
      end
    end

  assign ch.cnt   = cnt_q;
  assign ch.pulse = act_q;
endmodule

// file: core/tcop_top.sv
// tooth-corrected multiplied clock with four one-shot pulse channels
`timescale 1ns/100ps
`include "tcop_cfg.svh"
module tcop_top #(parameter int CW = 32)
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        tooth_input,
  output logic      [3:0]  pulse_outputs,
  output logic             cb5_tick,
  output logic             pulse_irq_line
);
  localparam int NCH = 4;

  if (CW < 8 || CW > 32)
  begin : g_bad_cw
    $error("tcop_top: counter width must be 8 to 32");
  end

  // byte-lane merge of a write into a register
  function automatic logic [31:0] wmask(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
      if (sel[b])
        r[8*b +: 8] = nw[8*b +: 8];
    return r;
  endfunction

  // counter value widened to the bus
  function automatic logic [31:0] wide(input logic [CW-1:0] v);
    return 32'(v);
  endfunction

  logic          ack_q;
  logic [31:0]   rdat_q;
  logic [31:0]   rd_d;
  logic          wr;
  logic [7:0]    ctrl_q;
  logic [7:0]    psc_div_q;
  logic [7:0]    psc_cnt_q;
  logic [CW-1:0] ratio_q;
  logic [CW-1:0] load_q;
  logic [CW-1:0] capt_q;
  logic [CW-1:0] itv_q;
  logic [CW-1:0] rldc_q;
  logic [CW-1:0] erld_q;
  logic [CW-1:0] cevt_q;
  logic [CW-1:0] medg_q;
  logic [CW-1:0] cclk_q;
  logic [CW-1:0] limit_q;
  logic [CW-1:0] mcnt_q;
  logic [CW-1:0] mcmp_q;
  logic [12:0]   status_q;
  logic          pt_start_q;
  logic [2:0]    pt_clksel_q;
  logic [CW-1:0] ofs_cnt_q;
  logic [CW-1:0] itv_cnt_q;
  logic [CW-1:0] ofs_cmp_q [NCH];
  logic [CW-1:0] itv_cmp_q;
  logic          cmpb_en_q;
  logic [15:0]   dctl_q;
  logic [CW-1:0] dwid_q [NCH];
  logic [2:0]    irq_sel_q;
  logic          irq_q;
  logic          ls_tick;
  logic          edge_evt;
  logic          ext_evt;
  logic          gen_en;
  logic          mult_raw;
  logic          agck;
  logic          r4_hit;
  logic [CW-1:0] ld_src;
  logic          tick_ofs;
  logic          tick_itv;
  logic          tick_dn;
  logic [NCH-1:0] cmpa;
  logic          cmpb;
  logic [12:0]   st_set;
  logic [12:0]   st_clr;
  logic [CW-1:0] dcnt_val [NCH];

  tcop_ch_if #(.CW(CW)) chif [NCH] ();

  // classic wishbone: ack one cycle after the request, dropped next cycle
  always_ff @(posedge clk or posedge rst)
    if (rst)
      ack_q <= 1'b0;
    else if (ce)
      ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
  assign wb_ack_o = ack_q;
  assign wr = ce & wb_cyc_i & wb_stb_i & wb_we_i & ack_q;

  // control and configuration registers
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      ctrl_q      <= `TCOP_RST_CTRL;
      psc_div_q   <= `TCOP_RST_PSC;
      ratio_q     <= CW'(`TCOP_RST_RATIO);
      load_q      <= '0;
      limit_q     <= CW'(`TCOP_RST_LIMIT);
      mcmp_q      <= '0;
      pt_start_q  <= 1'b0;
      pt_clksel_q <= 3'h0;
      itv_cmp_q   <= '0;
      cmpb_en_q   <= 1'b0;
      dctl_q      <= 16'h0000;
      irq_sel_q   <= 3'h0;
      for (int i = 0; i < NCH; i++)
      begin
        ofs_cmp_q[i] <= '0;
        dwid_q[i]    <= '0;
      end
    end
    else if (wr)
    begin
      if (wb_adr_i == `TCOP_OFS_CTRL)
        ctrl_q <= 8'(wmask(32'(ctrl_q), wb_dat_i, wb_sel_i));
      else if (wb_adr_i == `TCOP_OFS_PSC)
        psc_div_q <= 8'(wmask(32'(psc_div_q), wb_dat_i, wb_sel_i));
      else if (wb_adr_i == `TCOP_OFS_RATIO)
        ratio_q <= CW'(wmask(wide(ratio_q), wb_dat_i, wb_sel_i));
      else if (wb_adr_i == `TCOP_OFS_LOAD)
        load_q <= CW'(wmask(wide(load_q), wb_dat_i, wb_sel_i));
      else if (wb_adr_i == `TCOP_OFS_LIMIT)
        limit_q <= CW'(wmask(wide(limit_q), wb_dat_i, wb_sel_i));
      else if (wb_adr_i == `TCOP_OFS_MCMP)
        mcmp_q <= CW'(wmask(wide(mcmp_q), wb_dat_i, wb_sel_i));
      else if (wb_adr_i == `TCOP_OFS_PT_START && wb_sel_i[0])
        pt_start_q <= wb_dat_i[0];
      else if (wb_adr_i == `TCOP_OFS_PT_CLKSEL && wb_sel_i[0])
        pt_clksel_q <= wb_dat_i[2:0];
      else if (wb_adr_i == `TCOP_OFS_ITV_CMP)
        itv_cmp_q <= CW'(wmask(wide(itv_cmp_q), wb_dat_i, wb_sel_i));
      else if (wb_adr_i == `TCOP_OFS_CMPB_EN && wb_sel_i[0])
        cmpb_en_q <= wb_dat_i[0];
      else if (wb_adr_i == `TCOP_OFS_DCNT_CTRL)
        dctl_q <= 16'(wmask(32'(dctl_q), wb_dat_i, wb_sel_i));
      else if (wb_adr_i == `TCOP_OFS_IRQ_SEL && wb_sel_i[0])
        irq_sel_q <= wb_dat_i[2:0];
      for (int i = 0; i < NCH; i++)
      begin
        if (wb_adr_i == 8'(`TCOP_OFS_OFS_CMP0 + 4*i))
          ofs_cmp_q[i] <= CW'(wmask(wide(ofs_cmp_q[i]), wb_dat_i, wb_sel_i));
        if (wb_adr_i == 8'(`TCOP_OFS_DCNT0 + 4*i))
          dwid_q[i] <= CW'(wmask(wide(dwid_q[i]), wb_dat_i, wb_sel_i));
      end
    end

  // low-speed clock prescaler, period is divider plus one
  always_ff @(posedge clk or posedge rst)
    if (rst)
      psc_cnt_q <= 8'h00;
    else if (ce)
      psc_cnt_q <= ls_tick ? 8'h00 : psc_cnt_q + 8'h01;
  assign ls_tick = ce & (psc_cnt_q >= psc_div_q);

  tcop_edge u_edge (
    .clk         (clk),
    .rst         (rst),
    .ce          (ce),
    .tooth_input (tooth_input),
    .edge_sel    (ctrl_q[`TCOP_CTRL_EDGE_LO +: 2]),
    .edge_evt    (edge_evt)
  );
  assign gen_en  = ctrl_q[`TCOP_CTRL_GEN_EN];
  assign ext_evt = edge_evt & ctrl_q[`TCOP_CTRL_EVT_OUT] & gen_en;

  // interval measurement between tooth edges
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      itv_q  <= '0;
      capt_q <= '0;
    end
    else if (edge_evt)
    begin
      capt_q <= itv_q;
      itv_q  <= '0;
    end
    else if (ls_tick)
      itv_q <= itv_q + 1'b1;

  assign ld_src = ctrl_q[`TCOP_CTRL_LDSEL] ? load_q : itv_q;

  // multiplied clock: ratio pulses per source interval
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      rldc_q <= '0;
      erld_q <= '0;
    end
    else if (ext_evt)
    begin
      rldc_q <= ld_src - ratio_q;
      erld_q <= ld_src;
    end
    else if (gen_en && ls_tick)
    begin
      if (erld_q <= ratio_q)
        erld_q <= erld_q + rldc_q;
      else
        erld_q <= erld_q - ratio_q;
    end
  assign mult_raw = gen_en & ls_tick & ~ext_evt & (erld_q <= ratio_q);

  // correction event and multiplied edge counters
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      cevt_q <= '0;
      medg_q <= '0;
    end
    else if (wr && wb_adr_i == `TCOP_OFS_CEVT)
      cevt_q <= CW'(wmask(wide(cevt_q), wb_dat_i, wb_sel_i));
    else if (ext_evt)
    begin
      medg_q <= cevt_q;
      cevt_q <= cevt_q + ratio_q;
    end
    else if (mult_raw &&
             !(ctrl_q[`TCOP_CTRL_B4_STOP] && medg_q == cevt_q))
      medg_q <= medg_q + 1'b1;

  assign r4_hit = ext_evt & (cevt_q == '0) & (cclk_q == limit_q);
  assign agck = gen_en & ls_tick & ~r4_hit & (cclk_q < medg_q) &
                (cclk_q < limit_q);

  // correction clock counter
  always_ff @(posedge clk or posedge rst)
    if (rst)
      cclk_q <= '0;
    else if (wr && wb_adr_i == `TCOP_OFS_CCLK)
      cclk_q <= CW'(wmask(wide(cclk_q), wb_dat_i, wb_sel_i));
    else if (r4_hit)
      cclk_q <= CW'(1);
    else if (agck)
      cclk_q <= cclk_q + 1'b1;

  // multiplied clock counter, counts in quarter teeth at ratio four
  always_ff @(posedge clk or posedge rst)
    if (rst)
      mcnt_q <= '0;
    else if (wr && wb_adr_i == `TCOP_OFS_MCNT)
      mcnt_q <= CW'(wmask(wide(mcnt_q), wb_dat_i, wb_sel_i));
    else if (agck)
      mcnt_q <= mcnt_q + 1'b1;

  always_comb
  begin
    case (tcop_pkg::tcop_cb5_t'(ctrl_q[`TCOP_CTRL_CB5_LO +: 2]))
      tcop_pkg::TCOP_CB5_CORR: cb5_tick = agck;
      tcop_pkg::TCOP_CB5_MULT: cb5_tick = mult_raw;
      tcop_pkg::TCOP_CB5_EVT:  cb5_tick = ext_evt;
      default:                 cb5_tick = ls_tick;
    endcase
  end

  assign tick_ofs = pt_start_q & (pt_clksel_q[0] ? cb5_tick : ls_tick);
  assign tick_itv = pt_start_q & (pt_clksel_q[1] ? cb5_tick : ls_tick);
  assign tick_dn  = pt_start_q & (pt_clksel_q[2] ? cb5_tick : ls_tick);

  // offset and interval counters of the pulse timer
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      ofs_cnt_q <= '0;
      itv_cnt_q <= '0;
    end
    else if (ce)
    begin
      if (wr && wb_adr_i == `TCOP_OFS_OFS_CNT)
        ofs_cnt_q <= CW'(wmask(wide(ofs_cnt_q), wb_dat_i, wb_sel_i));
      else if (tick_ofs)
        ofs_cnt_q <= ofs_cnt_q + 1'b1;
      if (wr && wb_adr_i == `TCOP_OFS_ITV_CNT)
        itv_cnt_q <= CW'(wmask(wide(itv_cnt_q), wb_dat_i, wb_sel_i));
      else if (tick_itv)
        itv_cnt_q <= itv_cnt_q + 1'b1;
    end

  assign cmpb = cmpb_en_q & tick_itv & (itv_cnt_q == itv_cmp_q);

  // per channel match A, start/stop selection and down-counter
  for (genvar i = 0; i < NCH; i++)
  begin : g_ch
    logic [1:0] ssel;
    logic [1:0] psel;
    assign cmpa[i] = tick_ofs & (ofs_cnt_q == ofs_cmp_q[i]);
    assign ssel    = dctl_q[4*i +: 2];
    assign psel    = dctl_q[4*i+2 +: 2];
    assign chif[i].start = (ssel == tcop_pkg::TCOP_START_CMPA & cmpa[i]) |
                           (ssel == tcop_pkg::TCOP_START_CMPB & cmpb) |
                           (ssel == tcop_pkg::TCOP_START_ANY &
                            (cmpa[i] | cmpb));
    assign chif[i].stop  = (psel == tcop_pkg::TCOP_STOP_CMPB & cmpb) |
                           (psel == tcop_pkg::TCOP_STOP_CMPA & cmpa[i]) |
                           (psel == tcop_pkg::TCOP_STOP_ANY &
                            (cmpa[i] | cmpb));
    assign chif[i].tick  = tick_dn;
    assign chif[i].width = dwid_q[i];
    // live count copied out so the read mux can index it procedurally
    assign dcnt_val[i] = chif[i].cnt;
    assign pulse_outputs[i] = chif[i].pulse;
    tcop_dcnt #(.CW(CW)) u_dcnt (
      .clk (clk),
      .rst (rst),
      .ce  (ce),
      .ch  (chif[i])
    );
  end

  // sticky flags: capture, multiplied match, match A per channel, match B
  always_comb
  begin
    st_set = 13'h0000;
    st_set[`TCOP_ST_CAPT] = edge_evt;
    st_set[`TCOP_ST_MULT] = gen_en & (mcnt_q == mcmp_q);
    st_set[`TCOP_ST_CMPA_LO +: NCH] = cmpa;
    st_set[`TCOP_ST_CMPB] = cmpb;
    st_clr = 13'h0000;
    if (wr && wb_adr_i == `TCOP_OFS_CLEAR)
      st_clr = 13'(wmask(32'h0000_0000, wb_dat_i, wb_sel_i));
  end

  always_ff @(posedge clk or posedge rst)
    if (rst)
      status_q <= 13'h0000;
    else if (ce)
      status_q <= (status_q & ~st_clr) | st_set;

  always_ff @(posedge clk or posedge rst)
    if (rst)
      irq_q <= 1'b0;
    else if (ce)
    begin
      if (irq_sel_q < 3'h4)
        irq_q <= status_q[`TCOP_ST_CMPA_LO + 32'(irq_sel_q[1:0])];
      else if (irq_sel_q == 3'h4)
        irq_q <= status_q[`TCOP_ST_CMPB];
      else if (irq_sel_q == 3'h5)
        irq_q <= status_q[`TCOP_ST_CAPT];
      else
        irq_q <= status_q[`TCOP_ST_MULT];
    end
  assign pulse_irq_line = irq_q;

  // read multiplexer, unmapped addresses read zero
  always_comb
  begin
    rd_d = 32'h0000_0000;
    if (wb_adr_i == `TCOP_OFS_CTRL)
      rd_d = 32'(ctrl_q);
    else if (wb_adr_i == `TCOP_OFS_PSC)
      rd_d = 32'(psc_div_q);
    else if (wb_adr_i == `TCOP_OFS_RATIO)
      rd_d = wide(ratio_q);
    else if (wb_adr_i == `TCOP_OFS_LOAD)
      rd_d = wide(load_q);
    else if (wb_adr_i == `TCOP_OFS_CAPT)
      rd_d = wide(capt_q);
    else if (wb_adr_i == `TCOP_OFS_RLDC)
      rd_d = wide(rldc_q);
    else if (wb_adr_i == `TCOP_OFS_ERLD)
      rd_d = wide(erld_q);
    else if (wb_adr_i == `TCOP_OFS_CEVT)
      rd_d = wide(cevt_q);
    else if (wb_adr_i == `TCOP_OFS_MEDG)
      rd_d = wide(medg_q);
    else if (wb_adr_i == `TCOP_OFS_CCLK)
      rd_d = wide(cclk_q);
    else if (wb_adr_i == `TCOP_OFS_LIMIT)
      rd_d = wide(limit_q);
    else if (wb_adr_i == `TCOP_OFS_MCNT)
      rd_d = wide(mcnt_q);
    else if (wb_adr_i == `TCOP_OFS_MCMP)
      rd_d = wide(mcmp_q);
    else if (wb_adr_i == `TCOP_OFS_STATUS)
      rd_d = 32'(status_q);
    else if (wb_adr_i == `TCOP_OFS_PT_START)
      rd_d = 32'(pt_start_q);
    else if (wb_adr_i == `TCOP_OFS_PT_CLKSEL)
      rd_d = 32'(pt_clksel_q);
    else if (wb_adr_i == `TCOP_OFS_OFS_CNT)
      rd_d = wide(ofs_cnt_q);
    else if (wb_adr_i == `TCOP_OFS_ITV_CNT)
      rd_d = wide(itv_cnt_q);
    else if (wb_adr_i == `TCOP_OFS_ITV_CMP)
      rd_d = wide(itv_cmp_q);
    else if (wb_adr_i == `TCOP_OFS_CMPB_EN)
      rd_d = 32'(cmpb_en_q);
    else if (wb_adr_i == `TCOP_OFS_DCNT_CTRL)
      rd_d = 32'(dctl_q);
    else if (wb_adr_i == `TCOP_OFS_IRQ_SEL)
      rd_d = 32'(irq_sel_q);
    else if (wb_adr_i == `TCOP_OFS_PULSES)
      rd_d = 32'(pulse_outputs);
    for (int i = 0; i < NCH; i++)
    begin
      if (wb_adr_i == 8'(`TCOP_OFS_OFS_CMP0 + 4*i))
        rd_d = wide(ofs_cmp_q[i]);
      if (wb_adr_i == 8'(`TCOP_OFS_DCNT0 + 4*i))
        rd_d = wide(dcnt_val[i]);
    end
  end

  // read data captured with the request, presented with ack
  always_ff @(posedge clk or posedge rst)
    if (rst)
      rdat_q <= 32'h0000_0000;
    else if (ce && wb_cyc_i && wb_stb_i && !ack_q)
      rdat_q <= rd_d;
  assign wb_dat_o = rdat_q;
endmodule

// file: dv/tcop_tooth_src.sv
// toothed wheel model with a settable tooth period
`timescale 1ns/100ps
module tcop_tooth_src
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [7:0] period,
  output logic            tooth
);
  logic [7:0] cnt_q;
  // high for the first half of each period, low while stopped
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      cnt_q <= 8'h00;
      tooth <= 1'b0;
    end
    else
    begin
      cnt_q <= (cnt_q >= period) ? 8'h00 : cnt_q + 8'h01;
      tooth <= (period != 8'h00) && (cnt_q < {1'b0, period[7:1]});
    end
endmodule

// file: dv/tcop_top_assertions.sv
// bus and readback checks on the pulse block ports
`timescale 1ns/100ps
module tcop_top_assertions #(parameter int CW = 32)
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        ce,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        tooth_input,
  input wire logic [3:0]  pulse_outputs,
  input wire logic        cb5_tick,
  input wire logic        pulse_irq_line
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic req;
  // a fresh request not yet answered
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && ce;
  sequence s_rd(logic [7:0] a);
    req && !wb_we_i && wb_adr_i == a;
  endsequence
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");
  a_ack_latency: assert property (req ##1 ce |-> wb_ack_o)
    else $error("ack not one cycle after request");
  a_ack_needs_req: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  a_data_holds: assert property (!req |=> $stable(wb_dat_o))
    else $error("read data moved without request");
  a_hole_zero: assert property (s_rd(8'hFC) |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_clear_zero: assert property (s_rd(8'h38) |=> wb_dat_o == 32'h0)
    else $error("clear register read not zero");
  a_pulse_mirror: assert property (s_rd(8'h80) |=>
    wb_dat_o == {28'h0, $past(pulse_outputs)})
    else $error("pulse readback wrong");
  a_irq_by_write: assert property ($fell(pulse_irq_line) |->
    $past(wb_ack_o && wb_we_i) || $past(wb_ack_o && wb_we_i, 2))
    else $error("irq line fell without a write");
endmodule
bind tcop_top tcop_top_assertions #(.CW(CW)) u_chk (.clk(clk), .rst(rst),
  .ce(ce), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tooth_input(tooth_input),
  .pulse_outputs(pulse_outputs), .cb5_tick(cb5_tick),
  .pulse_irq_line(pulse_irq_line));

// file: dv/tooth_corrected_oneshot_pulse_test.sv
// random and corner scenarios for the tooth corrected pulse block
`timescale 1ns/100ps
`include "tcop_cfg.svh"
module tooth_corrected_oneshot_pulse_test;
  logic        clk, rst, cyc, stb, we, ack, tooth, cb5, irq;
  logic [7:0]  adr, period;
  logic [31:0] dat, dat_o, q, r, m;
  logic [3:0]  pulses;
  int          n_mismatch, n_compared, t, k, w[4], c[4], hi[4], up[4];
  logic [7:0]  ra[6] = '{`TCOP_OFS_CTRL, `TCOP_OFS_PSC, `TCOP_OFS_RATIO,
                         `TCOP_OFS_LIMIT, `TCOP_OFS_PT_START, 8'hFC};
  logic [31:0] rv[6] = '{`TCOP_RST_CTRL, `TCOP_RST_PSC, `TCOP_RST_RATIO,
                         `TCOP_RST_LIMIT, 0, 0};
  tcop_top #(.CW(32)) dut (.clk(clk), .rst(rst), .ce(1'b1), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .tooth_input(tooth),
    .pulse_outputs(pulses), .cb5_tick(cb5), .pulse_irq_line(irq));
  tcop_tooth_src src (.clk(clk), .rst(rst), .period(period), .tooth(tooth));
  always #2 clk = ~clk;
  // first rise time and high cycles of each pulse
  always @(posedge clk)
  begin
    t++;
    for (int i = 0; i < 4; i++)
    begin
      if (pulses[i] === 1'b1) hi[i]++;
      if (pulses[i] === 1'b1 && up[i] == 0) up[i] = t;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  // one classic cycle; read data lands in q
  task automatic bus(input logic w_, input logic [7:0] a,
                     input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w_;
    adr <= a;
    dat <= d;
    do
      @(posedge clk);
    while (ack !== 1'b1);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic edges(input int n);
    period <= 8'd40;
    repeat (n) @(posedge tooth);
    @(posedge clk);
    period <= 8'd0;
  endtask
  task automatic conclude;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    #(4 * 20000);
    n_mismatch++;
    conclude();
  end
  initial
  begin
    {clk, cyc, stb, we, adr, dat, period, n_mismatch, n_compared, t} = 0;
    rst = 1'b1;
    void'($urandom(32'h63020912));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    bus(1, 8'hFC, $urandom);
    foreach (ra[i])
    begin
      bus(0, ra[i], 0);
      chk(q, rv[i]);
    end
    $display("test reset values done");
    r = 1 + $urandom % 8;
    m = $urandom % 16'hFFFF;
    bus(1, `TCOP_OFS_PSC, 8'hFF);
    bus(1, `TCOP_OFS_RATIO, r);
    bus(1, `TCOP_OFS_LOAD, m);
    bus(1, `TCOP_OFS_CTRL, 8'h1F);
    edges(3);
    bus(0, `TCOP_OFS_CEVT, 0);
    chk(q, 3 * r);
    bus(0, `TCOP_OFS_MEDG, 0);
    chk(q >= 2 * r && q <= 3 * r, 1);
    bus(0, `TCOP_OFS_RLDC, 0);
    chk(q, m - r);
    bus(0, `TCOP_OFS_STATUS, 0);
    chk(q[0], 1);
    bus(1, `TCOP_OFS_CLEAR, 1);
    bus(0, `TCOP_OFS_STATUS, 0);
    chk(q[0], 0);
    bus(1, `TCOP_OFS_LIMIT, 20);
    bus(1, `TCOP_OFS_CCLK, 20);
    bus(1, `TCOP_OFS_CEVT, 0);
    edges(1);
    bus(0, `TCOP_OFS_CCLK, 0);
    chk(q, 1);
    $display("test tooth events done");
    m = 1 + $urandom % 1000;
    bus(1, `TCOP_OFS_IRQ_SEL, 6);
    bus(1, `TCOP_OFS_MCMP, m);
    bus(1, `TCOP_OFS_MCNT, m);
    bus(0, `TCOP_OFS_STATUS, 0);
    chk(q[1], 1);
    chk(irq, 1);
    bus(1, `TCOP_OFS_MCMP, m + 500);
    bus(1, `TCOP_OFS_CLEAR, 2);
    @(posedge clk);
    bus(0, `TCOP_OFS_STATUS, 0);
    chk(q[1], 0);
    chk(irq, 0);
    bus(0, `TCOP_OFS_CLEAR, 0);
    chk(q, 0);
    $display("test multiplied match done");
    bus(1, `TCOP_OFS_PSC, 0);
    for (int i = 0; i < 4; i++)
    begin
      w[i] = 1 + $urandom % 6;
      c[i] = 6 + 4 * i + $urandom % 3;
      bus(1, `TCOP_OFS_OFS_CMP0 + 8'(4 * i), c[i]);
      bus(1, `TCOP_OFS_DCNT0 + 8'(4 * i), w[i]);
    end
    bus(1, `TCOP_OFS_DCNT_CTRL, 16'h1111);
    bus(1, `TCOP_OFS_CMPB_EN, 1);
    bus(1, `TCOP_OFS_ITV_CMP, 2);
    chk(pulses, 0);
    hi = '{0, 0, 0, 0};
    up = '{0, 0, 0, 0};
    bus(1, `TCOP_OFS_PT_START, 1);
    repeat (c[0]) @(posedge clk);
    bus(0, `TCOP_OFS_PULSES, 0);
    chk(q[3:0], 4'h1);
    repeat (60) @(posedge clk);
    for (int i = 0; i < 4; i++)
    begin
      chk(hi[i], w[i] + 1);
      chk(up[i] - up[0], c[i] - c[0]);
    end
    bus(0, `TCOP_OFS_STATUS, 0);
    chk(q[12:8], 5'h1F);
    bus(1, `TCOP_OFS_CLEAR, 32'h1F00);
    bus(0, `TCOP_OFS_STATUS, 0);
    chk(q[12:8], 0);
    $display("test pulse channels done");
    bus(1, `TCOP_OFS_PSC, 3);
    k = 0;
    repeat (40) @(posedge clk) k += cb5;
    chk(k, 10);
    bus(1, `TCOP_OFS_PSC, 0);
    bus(1, `TCOP_OFS_RATIO, 4);
    bus(1, `TCOP_OFS_LIMIT, 32'hFFFF_FFFF);
    bus(1, `TCOP_OFS_CTRL, 8'hD9);
    period <= 8'd63;
    k = 0;
    repeat (256) @(posedge clk) k += cb5;
    chk(k, 4);
    repeat (3) @(posedge tooth);
    @(posedge clk);
    bus(0, `TCOP_OFS_MCNT, 0);
    m = q;
    repeat (3) @(posedge tooth);
    @(posedge clk);
    bus(0, `TCOP_OFS_MCNT, 0);
    chk(q - m, 12);
    bus(1, `TCOP_OFS_CTRL, 8'hF9);
    bus(1, `TCOP_OFS_PT_CLKSEL, 7);
    repeat (2) @(posedge tooth);
    @(posedge clk);
    bus(0, `TCOP_OFS_OFS_CNT, 0);
    m = q;
    repeat (2) @(posedge tooth);
    @(posedge clk);
    bus(0, `TCOP_OFS_OFS_CNT, 0);
    chk(q - m, 4);
    $display("test corrected clock done");
    conclude();
  end
endmodule
